//--- logic/conv_ctrl_regs.vh
`ifndef CONV_CTRL_REGS_VH
`define CONV_CTRL_REGS_VH
// clock period in ps (50 MHz)
`define CLK_PERIOD_PS 20000
// conversion must finish within this time, ps
`define CONV_TIME_MAX_PS 4700000
// least acquisition interval the host must allow, ps
`define ACQ_TIME_MIN_PS 1100000
// internal conversion clock divider (mclk cycles per bit step)
`define CONV_CLK_DIV 8
// result width and byte width
`define RESULT_WIDTH 16
`define BYTE_WIDTH 8
// fifo depth on the result path
`define RESULT_FIFO_DEPTH 8
// power mode encodings
`define PWR_STANDBY 1'b0
`define PWR_SHUTDOWN 1'b1
`endif

//--- logic/result_fifo.v
`timescale 1ns/100ps
module result_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
)(
   input wire mclk,
   input wire rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   assign in_ready = (count_reg != DEPTH);
   assign out_valid = (count_reg != 0);
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge mclk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
      if (rst)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

//--- logic/sar_conv_ctrl.v
// Overview of operation
// - second strobe fall ends acquisition and holds the sample
// - after each conversion the latched power mode is entered
// - conversion clock is generated internally
// - conversion finishes within the maximum conversion time after hold
// - done output goes low once the result is ready
// - result is a 16-bit binary word from the approximation register
// - data lines are driven only while a result is presented
// - high byte select picks msb or lsb in byte-wide mode
`timescale 1ns/100ps
`include "conv_ctrl_regs.vh"
module sar_conv_ctrl #(
   parameter BYTE_MODE = 0,
   parameter CONV_DIV = `CONV_CLK_DIV
)(
   input wire mclk,
   input wire rst,
   input wire convert_strobe_n,
   input wire read_convert_sel,
   input wire high_byte_select,
   input wire comparator_in,
   output reg track_hold_n,
   output reg dac_enable,
   output reg [`RESULT_WIDTH-1:0] dac_code,
   output reg ref_power_on,
   output reg conv_done_n,
   output reg [`RESULT_WIDTH-1:0] data_out,
   output reg [`RESULT_WIDTH-1:0] data_oe
);
   localparam W = `RESULT_WIDTH;
   localparam integer CONV_MAX_CYC = `CONV_TIME_MAX_PS / `CLK_PERIOD_PS;
   localparam integer CONV_CYC = (W + 2) * CONV_DIV;
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ACQ = 3'h1;
   localparam [2:0] ST_CONV = 3'h2;
   localparam [2:0] ST_DONE = 3'h3;
   localparam [2:0] ST_READ = 3'h4;
   reg cs_s1_reg;
   reg cs_s2_reg;
   reg cs_s3_reg;
   reg rc_s1_reg;
   reg rc_s2_reg;
   reg hb_s1_reg;
   reg hb_s2_reg;
   // comparator settles asynchronously; CONV_DIV must be at least 3 for these flops
   reg cmp_s1_reg;
   reg cmp_s2_reg;
   reg [2:0] state_reg;
   reg pwr_mode_reg;
   reg [7:0] div_reg;
   reg [4:0] bit_reg;
   reg [W-1:0] sar_reg;
   reg fifo_pop_reg;
   wire cs_fall;
   wire cs_rise;
   wire div_tick;
   wire [W-1:0] fifo_data;
   wire fifo_valid;
   wire fifo_in_ready;
   wire [W-1:0] present;
   wire [W-1:0] lane_oe;
   // edge register resets to the idle level of the strobe, so reset makes no edge
   assign cs_fall = cs_s3_reg && !cs_s2_reg;
   assign cs_rise = !cs_s3_reg && cs_s2_reg;
   assign div_tick = (div_reg == CONV_DIV - 1);
   // per data line: byte-wide parts show either byte on the low eight lines
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_line
         if (BYTE_MODE == 0)
         begin : g_wide
            assign present[g] = fifo_data[g];
            assign lane_oe[g] = 1'b1;
         end
         else if (g < `BYTE_WIDTH)
         begin : g_byte
            assign present[g] = hb_s2_reg ? fifo_data[g + `BYTE_WIDTH] : fifo_data[g];
            assign lane_oe[g] = 1'b1;
         end
         else
         begin : g_unused
            assign present[g] = 1'b0;
            assign lane_oe[g] = 1'b0;
         end
      end
   endgenerate
   // results wait here until read, or until a new acquisition drops them
   result_fifo #(
      .WIDTH(W),
      .DEPTH(`RESULT_FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_data(sar_reg),
      .in_valid(state_reg == ST_CONV && bit_reg == 5'd16 && div_tick),
      .in_ready(fifo_in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop_reg)
   );
   always @(posedge mclk)
   begin
      cs_s1_reg <= convert_strobe_n;
      cs_s2_reg <= cs_s1_reg;
      rc_s1_reg <= read_convert_sel;
      rc_s2_reg <= rc_s1_reg;
      hb_s1_reg <= high_byte_select;
      hb_s2_reg <= hb_s1_reg;
      cmp_s1_reg <= comparator_in;
      cmp_s2_reg <= cmp_s1_reg;
      if (rst)
      begin
         cs_s3_reg <= 1'b1;
         state_reg <= ST_IDLE;
         pwr_mode_reg <= `PWR_SHUTDOWN;
         div_reg <= 8'h00;
         bit_reg <= 5'h00;
         sar_reg <= {W{1'b0}};
         fifo_pop_reg <= 1'b0;
         track_hold_n <= 1'b1;
         dac_enable <= 1'b0;
         dac_code <= {W{1'b0}};
         ref_power_on <= 1'b0;
         conv_done_n <= 1'b1;
         data_out <= {W{1'b0}};
         data_oe <= {W{1'b0}};
      end
      else
      begin
         cs_s3_reg <= cs_s2_reg;
         fifo_pop_reg <= 1'b0;
         div_reg <= div_tick ? 8'h00 : div_reg + 8'h01;
         case (state_reg)
            ST_IDLE, ST_DONE:
            begin
               if (cs_fall && !rc_s2_reg)
               begin
                  state_reg <= ST_ACQ;
                  ref_power_on <= 1'b1;
                  track_hold_n <= 1'b0;
                  conv_done_n <= 1'b1;
                  if (fifo_valid)
                  begin
                     fifo_pop_reg <= 1'b1;
                  end
               end
               else if (cs_fall && state_reg == ST_DONE && fifo_valid)
               begin
                  state_reg <= ST_READ;
                  data_out <= present;
                  data_oe <= lane_oe;
               end
            end
            ST_ACQ:
            begin
               if (cs_fall)
               begin
                  track_hold_n <= 1'b1;
                  pwr_mode_reg <= rc_s2_reg;
                  state_reg <= ST_CONV;
                  sar_reg <= {1'b1, {(W-1){1'b0}}};
                  dac_code <= {1'b1, {(W-1){1'b0}}};
                  dac_enable <= 1'b1;
                  bit_reg <= 5'h00;
                  div_reg <= 8'h00;
               end
            end
            ST_CONV:
            begin
               // strobe edges are not looked at here
               if (div_tick)
               begin
                  if (bit_reg < 5'd16)
                  begin
                     sar_reg[W-1-bit_reg[3:0]] <= cmp_s2_reg;
                     if (bit_reg < 5'd15)
                     begin
                        sar_reg[W-2-bit_reg[3:0]] <= 1'b1;
                        dac_code <= (sar_reg & ~({{(W-1){1'b0}}, 1'b1} << (W-1-bit_reg[3:0])))
                           | ({{(W-1){1'b0}}, cmp_s2_reg} << (W-1-bit_reg[3:0]))
                           | ({{(W-1){1'b0}}, 1'b1} << (W-2-bit_reg[3:0]));
                     end
                     bit_reg <= bit_reg + 5'd1;
                  end
                  else if (fifo_in_ready)
                  begin
                     state_reg <= ST_DONE;
                     conv_done_n <= 1'b0;
                     dac_enable <= 1'b0;
                     ref_power_on <= (pwr_mode_reg == `PWR_STANDBY);
                  end
               end
            end
            ST_READ:
            begin
               // byte select may change while the bus is driven
               data_out <= present;
               if (cs_rise)
               begin
                  data_oe <= {W{1'b0}};
                  fifo_pop_reg <= 1'b1;
                  conv_done_n <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

//--- verification/conv_monitor.sv
`timescale 1ns/100ps
module conv_monitor (
   input wire mclk,
   input wire rst,
   input wire convert_strobe_n,
   input wire read_convert_sel,
   input wire high_byte_select,
   input wire comparator_in,
   input wire track_hold_n,
   input wire dac_enable,
   input wire [15:0] dac_code,
   input wire ref_power_on,
   input wire conv_done_n,
   input wire [15:0] data_out,
   input wire [15:0] data_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   AST_HOLD_CONV: assert property (dac_enable |-> track_hold_n)
      else $error("conversion while tracking");
   AST_REF_CONV: assert property (dac_enable |-> ref_power_on)
      else $error("reference off during conversion");
   AST_INT_CLK: assert property ($rose(dac_enable) |-> ##[1:20] $changed(dac_code))
      else $error("no internal step");
   AST_CONV_TIME: assert property ($rose(track_hold_n) |-> ##[1:235] $fell(conv_done_n))
      else $error("conversion too slow");
   AST_DONE_WAIT: assert property ($rose(dac_enable) |-> conv_done_n [*8])
      else $error("done too early");
   AST_OE_TRACK: assert property (!track_hold_n |-> data_oe == 16'h0000)
      else $error("bus driven while tracking");
   AST_OE_DONE: assert property ($rose(|data_oe) |-> !conv_done_n)
      else $error("bus driven without result");
   AST_RELEASE: assert property ($rose(convert_strobe_n) && (|data_oe) |-> ##[1:6] data_oe == 16'h0000)
      else $error("bus not released");
   AST_IGNORE: assert property (dac_enable && $fell(convert_strobe_n) |-> ##4 track_hold_n)
      else $error("strobe not ignored");
endmodule
bind sar_conv_ctrl conv_monitor i_mon (.mclk(mclk), .rst(rst), .convert_strobe_n(convert_strobe_n),
   .read_convert_sel(read_convert_sel), .high_byte_select(high_byte_select),
   .comparator_in(comparator_in), .track_hold_n(track_hold_n), .dac_enable(dac_enable),
   .dac_code(dac_code), .ref_power_on(ref_power_on), .conv_done_n(conv_done_n),
   .data_out(data_out), .data_oe(data_oe));

//--- verification/comparator_model.sv
`timescale 1ns/100ps
module comparator_model (
   input wire mclk,
   input wire track_hold_n,
   input wire [15:0] dac_code,
   input wire [15:0] level,
   output wire comparator_in
);
   reg [15:0] held_reg;
   // follows the input while tracking, frozen in hold
   always @(posedge mclk)
      if (!track_hold_n)
         held_reg <= level;
   assign comparator_in = (dac_code <= held_reg);
endmodule

//--- verification/tb.sv
`timescale 1ns/100ps
module tb;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg convert_strobe_n = 1'b1;
   reg read_convert_sel = 1'b0;
   reg [15:0] level = 16'h0000;
   reg high_byte_select = 1'b1;
   wire comparator_in, track_hold_n, dac_enable, ref_power_on, conv_done_n;
   wire [15:0] dac_code, data_out, data_oe;
   wire byte_cmp, byte_track;
   wire [15:0] byte_code, byte_data, byte_oe;
   integer mismatches = 0;
   integer tests_run = 0;
   integer i;
   integer n;
   reg [17:0] rows [0:3];
   initial
      forever #10 mclk = ~mclk;
   sar_conv_ctrl i_dut (.mclk(mclk), .rst(rst), .convert_strobe_n(convert_strobe_n),
      .read_convert_sel(read_convert_sel), .high_byte_select(high_byte_select),
      .comparator_in(comparator_in), .track_hold_n(track_hold_n), .dac_enable(dac_enable),
      .dac_code(dac_code), .ref_power_on(ref_power_on), .conv_done_n(conv_done_n),
      .data_out(data_out), .data_oe(data_oe));
   comparator_model i_cmp (.mclk(mclk), .track_hold_n(track_hold_n), .dac_code(dac_code),
      .level(level), .comparator_in(comparator_in));
   sar_conv_ctrl #(.BYTE_MODE(1)) i_dut_byte (.mclk(mclk), .rst(rst),
      .convert_strobe_n(convert_strobe_n), .read_convert_sel(read_convert_sel),
      .high_byte_select(high_byte_select), .comparator_in(byte_cmp),
      .track_hold_n(byte_track), .dac_enable(), .dac_code(byte_code), .ref_power_on(),
      .conv_done_n(), .data_out(byte_data), .data_oe(byte_oe));
   comparator_model i_cmp_byte (.mclk(mclk), .track_hold_n(byte_track), .dac_code(byte_code),
      .level(level), .comparator_in(byte_cmp));
   task chk(input string name, input [15:0] e, input [15:0] g);
      tests_run = tests_run + 1;
      if (g !== e)
      begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask
   task pulse(input sel);
      @(negedge mclk);
      read_convert_sel = sel;
      convert_strobe_n = 1'b0;
      repeat (6) @(negedge mclk);
      convert_strobe_n = 1'b1;
      repeat (6) @(negedge mclk);
   endtask
   task conclude;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches = mismatches + 1;
      conclude;
   end
   initial
   begin
      // extra strobe during conversion, sample, power mode select
      rows[0] = {1'b0, 16'h1234, 1'b0};
      rows[1] = {1'b0, 16'hFFFF, 1'b1};
      rows[2] = {1'b1, 16'h0000, 1'b0};
      rows[3] = {1'b1, 16'h8001, 1'b1};
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk("reset_oe", 16'h0000, data_oe);
      chk("reset_done", 16'h0001, {15'h0000, conv_done_n});
      chk("reset_hold", 16'h0001, {15'h0000, track_hold_n});
      chk("reset_ref", 16'h0000, {15'h0000, ref_power_on});
      for (i = 0; i < 4; i = i + 1)
      begin
         level = rows[i][16:1];
         pulse(1'b0);
         chk("acq_track", 16'h0000, {15'h0000, track_hold_n});
         chk("acq_ref", 16'h0001, {15'h0000, ref_power_on});
         repeat (60) @(negedge mclk);
         pulse(rows[i][0]);
         chk("hold", 16'h0001, {15'h0000, track_hold_n});
         chk("converting", 16'h0001, {15'h0000, dac_enable});
         level = ~rows[i][16:1];
         if (rows[i][17])
            pulse(1'b1);
         n = 0;
         while (conv_done_n !== 1'b0 && n < 300)
         begin
            @(negedge mclk);
            n = n + 1;
         end
         chk("conv_time", 16'h0001, {15'h0000, n < 205});
         chk("ref_power", {15'h0000, ~rows[i][0]}, {15'h0000, ref_power_on});
         chk("conv_end", 16'h0000, {15'h0000, dac_enable});
         read_convert_sel = 1'b1;
         high_byte_select = 1'b1;
         convert_strobe_n = 1'b0;
         repeat (6) @(negedge mclk);
         chk("data_oe", 16'hFFFF, data_oe);
         chk("result", rows[i][16:1], data_out);
         chk("byte_oe", 16'h00FF, byte_oe);
         chk("byte_high", {8'h00, rows[i][16:9]}, byte_data);
         high_byte_select = 1'b0;
         repeat (4) @(negedge mclk);
         chk("byte_low", {8'h00, rows[i][8:1]}, byte_data);
         convert_strobe_n = 1'b1;
         repeat (6) @(negedge mclk);
         chk("release", 16'h0000, data_oe);
      end
      read_convert_sel = 1'b1;
      convert_strobe_n = 1'b0;
      repeat (6) @(negedge mclk);
      chk("idle_read", 16'h0000, data_oe);
      convert_strobe_n = 1'b1;
      repeat (6) @(negedge mclk);
      // reset in mid-conversion, then a fresh acquisition
      pulse(1'b0);
      repeat (60) @(negedge mclk);
      pulse(1'b0);
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      chk("mid_reset_conv", 16'h0000, {15'h0000, dac_enable});
      chk("mid_reset_oe", 16'h0000, data_oe);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk("mid_reset_ref", 16'h0000, {15'h0000, ref_power_on});
      chk("mid_reset_done", 16'h0001, {15'h0000, conv_done_n});
      pulse(1'b0);
      chk("reset_acq", 16'h0000, {15'h0000, track_hold_n});
      conclude;
   end
endmodule
